// ===== src/status_byte_service_request.sv
// status byte, service request mask, display saver and screen image dump
`timescale 1ns/10ps
module status_byte_service_request
  import stb_pkg::*;
#(
  parameter int SAVER_IDLE_CYC = SAVER_IDLE_CYCLES,
  parameter int FRAME_WORDS    = 1024,
  parameter int PIX_W          = 8
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  // command port from the remote interface
  input  wire logic             i_cmd_valid,
  input  wire logic [2:0]       i_cmd_code,
  input  wire logic [7:0]       i_cmd_data,
  output logic                  o_rsp_valid,
  output logic [7:0]            o_rsp_data,
  output logic                  o_service_request,
  // status sources
  input  wire logic             i_event_summary,
  input  wire logic             i_queue_not_empty,
  input  wire logic             i_value_adjusted_flag,
  input  wire logic             i_internal_change_flag,
  // display
  input  wire logic             i_user_activity,
  input  wire logic             i_pix_we,
  input  wire logic [$clog2(FRAME_WORDS)-1:0] i_pix_addr,
  input  wire logic [PIX_W-1:0] i_pix_data,
  output logic                  o_display_off,
  // image dump stream
  output logic                  o_dump_valid,
  output logic [PIX_W-1:0]      o_dump_data,
  output logic                  o_dump_last,
  output logic                  o_dump_busy
);
  localparam int AW = $clog2(FRAME_WORDS);

  function automatic logic [7:0] place_bit6(input logic [7:0] s, input logic b);
    logic [7:0] r;
    r = s;
    r[BIT_SUMMARY] = b;
    return r;
  endfunction

  logic        cmd_go;
  logic [7:0]  mask_q;
  logic        vab_q;
  logic        inb_q;
  logic        rqs_q;
  logic        mss_prev_q;
  logic [7:0]  status_w;
  logic        mss;
  logic        poll_now;
  logic        clear_now;
  logic        saver_en_q;
  logic [31:0] idle_cnt_q;
  logic        display_off_q;
  logic        rsp_valid_q;
  logic [7:0]  rsp_data_q;
  dump_state_t dump_state_q;
  logic        dump_busy_q;
  logic [AW-1:0] rd_addr_q;
  logic        rd_pend_q;
  logic        rd_last_q;
  logic        dump_valid_q;
  logic        dump_last_q;
  logic [PIX_W-1:0] dump_data_q;

  frame_mem_if #(.AW(AW), .DW(PIX_W)) fmem ();

  frame_store #(.WORDS(FRAME_WORDS)) u_frame_store (
    .i_clk (i_clk),
    .mem   (fmem.store)
  );

  assign cmd_go    = i_cmd_valid;
  assign poll_now  = cmd_go && (cmd_t'(i_cmd_code) == CMD_SERIAL_POLL);
  assign clear_now = cmd_go && (cmd_t'(i_cmd_code) == CMD_CLEAR);

  // status byte built live from its sources; bit 6 filled per read kind
  always_comb begin
    status_w                = 8'h00;
    status_w[BIT_EVENT]     = i_event_summary;
    status_w[BIT_QUEUE]     = i_queue_not_empty;
    status_w[BIT_VALUE_ADJ] = vab_q;
    status_w[BIT_INTERNAL]  = inb_q;
  end

  assign mss = |(status_w & mask_q);

  // service request mask
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mask_q <= MASK_RESET;
    end else if (cmd_go && cmd_t'(i_cmd_code) == CMD_MASK_WRITE) begin
      mask_q <= i_cmd_data & MASK_WRITABLE;
    end
  end

  // sticky adjusted / internal-change bits; a new event beats a clear
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      vab_q <= 1'b0;
      inb_q <= 1'b0;
    end else begin
      vab_q <= i_value_adjusted_flag  | (vab_q & ~clear_now);
      inb_q <= i_internal_change_flag | (inb_q & ~clear_now);
    end
  end

  // request flag raised on a new summary, dropped by a serial poll
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rqs_q      <= 1'b0;
      mss_prev_q <= 1'b0;
    end else begin
      mss_prev_q <= mss;
      rqs_q      <= (mss & ~mss_prev_q) | (rqs_q & ~poll_now & ~clear_now);
    end
  end

  // query answers, one cycle after the command
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 8'h00;
    end else begin
      rsp_valid_q <= 1'b0;
      if (cmd_go) begin
        case (cmd_t'(i_cmd_code))
          CMD_MASK_QUERY: begin
            rsp_valid_q <= 1'b1;
            rsp_data_q  <= mask_q;
          end
          CMD_STATUS_QUERY: begin
            rsp_valid_q <= 1'b1;
            rsp_data_q  <= place_bit6(status_w, mss);
          end
          CMD_SERIAL_POLL: begin
            rsp_valid_q <= 1'b1;
            rsp_data_q  <= place_bit6(status_w, rqs_q);
          end
          CMD_SAVER_QUERY: begin
            rsp_valid_q <= 1'b1;
            rsp_data_q  <= saver_en_q ? SAVER_YES : SAVER_NO;
          end
          default: begin
            rsp_valid_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // screen saver: only the panel blanks, nothing else is gated by it
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      saver_en_q <= SAVER_RESET;
    end else if (cmd_go && cmd_t'(i_cmd_code) == CMD_SAVER_SET) begin
      saver_en_q <= (i_cmd_data == SAVER_YES);
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      idle_cnt_q    <= 32'h0000_0000;
      display_off_q <= 1'b0;
    end else if (!saver_en_q || i_user_activity) begin
      idle_cnt_q    <= 32'h0000_0000;
      display_off_q <= 1'b0;
    end else if (idle_cnt_q == 32'(SAVER_IDLE_CYC - 1)) begin
      display_off_q <= 1'b1;
    end else begin
      idle_cnt_q    <= idle_cnt_q + 32'h0000_0001;
    end
  end

  // image dump: walk the frame store, one word per cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      dump_state_q <= DUMP_IDLE;
      dump_busy_q  <= 1'b0;
      rd_addr_q    <= '0;
    end else begin
      case (dump_state_q)
        DUMP_IDLE: begin
          if (cmd_go && cmd_t'(i_cmd_code) == CMD_DUMP) begin
            dump_state_q <= DUMP_READ;
            dump_busy_q  <= 1'b1;
            rd_addr_q    <= '0;
          end
        end
        DUMP_READ: begin
          rd_addr_q <= rd_addr_q + AW'(1);
          if (rd_addr_q == AW'(FRAME_WORDS - 1)) begin
            dump_state_q <= DUMP_DRAIN;
          end
        end
        DUMP_DRAIN: begin
          if (!rd_pend_q && !dump_valid_q) begin
            dump_state_q <= DUMP_IDLE;
            dump_busy_q  <= 1'b0;
          end
        end
        default: begin
          dump_state_q <= DUMP_IDLE;
          dump_busy_q  <= 1'b0;
        end
      endcase
    end
  end

  assign fmem.wr_en   = i_pix_we;
  assign fmem.wr_addr = i_pix_addr;
  assign fmem.wr_data = i_pix_data;
  assign fmem.rd_en   = (dump_state_q == DUMP_READ);
  assign fmem.rd_addr = rd_addr_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rd_pend_q    <= 1'b0;
      rd_last_q    <= 1'b0;
      dump_valid_q <= 1'b0;
      dump_last_q  <= 1'b0;
      dump_data_q  <= '0;
    end else begin
      rd_pend_q    <= fmem.rd_en;
      rd_last_q    <= fmem.rd_en && (rd_addr_q == AW'(FRAME_WORDS - 1));
      dump_valid_q <= rd_pend_q;
      dump_last_q  <= rd_last_q;
      if (rd_pend_q) begin
        dump_data_q <= fmem.rd_data;
      end
    end
  end

  assign o_rsp_valid       = rsp_valid_q;
  assign o_rsp_data        = rsp_data_q;
  assign o_service_request = rqs_q;
  assign o_display_off     = display_off_q;
  assign o_dump_valid      = dump_valid_q;
  assign o_dump_data       = dump_data_q;
  assign o_dump_last       = dump_last_q;
  assign o_dump_busy       = dump_busy_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_mask_write_store: assert property (
    cmd_go && cmd_t'(i_cmd_code) == CMD_MASK_WRITE
    |=> mask_q == ($past(i_cmd_data) & MASK_WRITABLE))
    else $error("mask not stored from write");
  chk_zero_mask_quiet: assert property (
    (mask_q == 8'h00 && !rqs_q) |=> !rqs_q)
    else $error("service request raised with empty mask");
  chk_mask_query_echo: assert property (
    cmd_go && cmd_t'(i_cmd_code) == CMD_MASK_QUERY
    |=> o_rsp_valid && o_rsp_data == $past(mask_q))
    else $error("mask query answer wrong");
  chk_mask_bit6_zero: assert property (
    !mask_q[BIT_SUMMARY])
    else $error("mask bit 6 set");
  chk_status_query_byte: assert property (
    cmd_go && cmd_t'(i_cmd_code) == CMD_STATUS_QUERY
    |=> o_rsp_valid && o_rsp_data[BIT_SUMMARY] == $past(mss)
        && o_rsp_data[BIT_QUEUE] == $past(i_queue_not_empty))
    else $error("status query answer wrong");
  chk_poll_rqs_bit: assert property (
    poll_now |=> o_rsp_valid && o_rsp_data[BIT_SUMMARY] == $past(rqs_q)
                 && o_rsp_data[BIT_EVENT] == $past(i_event_summary))
    else $error("serial poll bit 6 wrong");
  chk_summary_raises_rqs: assert property (
    (mss && !mss_prev_q) |=> rqs_q)
    else $error("new summary did not request service");
  chk_value_adj_sticky: assert property (
    i_value_adjusted_flag |=> vab_q ##0 (vab_q || $past(clear_now)))
    else $error("adjusted bit not set");
  chk_internal_sticky: assert property (
    i_internal_change_flag |=> inb_q)
    else $error("internal change bit not set");
  chk_reserved_zero: assert property (
    o_rsp_valid && $past(cmd_go && cmd_t'(i_cmd_code) == CMD_STATUS_QUERY)
    |-> (o_rsp_data & STATUS_RSVD) == 8'h00)
    else $error("reserved status bit nonzero");
  chk_saver_blanks: assert property (
    saver_en_q && !i_user_activity && idle_cnt_q == 32'(SAVER_IDLE_CYC - 1)
    |=> o_display_off)
    else $error("display not blanked after idle time");
  chk_dump_starts: assert property (
    cmd_go && cmd_t'(i_cmd_code) == CMD_DUMP && dump_state_q == DUMP_IDLE
    |-> ##3 o_dump_valid)
    else $error("dump data did not start");

  cov_service_request: cover property (mss && !mss_prev_q ##1 poll_now);
  cov_saver_active:    cover property (!o_display_off ##1 o_display_off);
  cov_dump_done:       cover property (o_dump_valid && o_dump_last);
endmodule // status_byte_service_request

// ===== src/stb_pkg.sv
// constants, command codes and states for the status byte and service request block
// Notes on behaviour
// - mask accepts any 8-bit value 0 to 255
// - cleared mask bits block their service request
// - mask query returns the stored mask bits
// - mask bit 6 unwritable, always reads zero
// - status query: bits 0-5, 7, summary in 6
// - serial poll puts request flag in bit 6
// - summary set when any enabled status bit set
// - bit 5 shows enabled standard event occurred
// - bit 4 set while output queue not empty
// - bit 2 set when command value was adjusted
// - bit 0 set on enabled internal state change
// - bits 7, 3, 1 always read zero
// - saver blanks display after idle; yes/no queryable
// - saver leaves all other functions running
// - dump command sends display image to controller
// - event bit follows enabled events since last clear; here bit 5 is i_event_summary taken live, and CMD_CLEAR does not touch it
package stb_pkg;

  localparam int CLK_PERIOD_NS     = 100;
  localparam int SAVER_IDLE_MS     = 1000;
  localparam int SAVER_IDLE_CYCLES =
    int'((64'(SAVER_IDLE_MS) * 64'd1000000) / 64'(CLK_PERIOD_NS));

  localparam int BIT_INTERNAL  = 0;
  localparam int BIT_VALUE_ADJ = 2;
  localparam int BIT_QUEUE     = 4;
  localparam int BIT_EVENT     = 5;
  localparam int BIT_SUMMARY   = 6;

  localparam logic [7:0] MASK_WRITABLE = 8'hBF;
  localparam logic [7:0] STATUS_RSVD   = 8'h8A;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic       SAVER_RESET   = 1'b0;
  localparam logic [7:0] SAVER_YES     = 8'h01;
  localparam logic [7:0] SAVER_NO      = 8'h00;

  typedef enum logic [2:0] {
    CMD_MASK_WRITE   = 3'h0,
    CMD_MASK_QUERY   = 3'h1,
    CMD_STATUS_QUERY = 3'h2,
    CMD_SERIAL_POLL  = 3'h3,
    CMD_SAVER_SET    = 3'h4,
    CMD_SAVER_QUERY  = 3'h5,
    CMD_DUMP         = 3'h6,
    CMD_CLEAR        = 3'h7
  } cmd_t;

  typedef enum logic [2:0] {
    DUMP_IDLE  = 3'b001,
    DUMP_READ  = 3'b010,
    DUMP_DRAIN = 3'b100
  } dump_state_t;

endpackage

// ===== src/frame_mem_if.sv
// display image store port between the block and its frame memory
`timescale 1ns/10ps
interface frame_mem_if #(
  parameter int AW = 10,
  parameter int DW = 8
);
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic          rd_en;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport owner (output wr_en, output wr_addr, output wr_data,
                 output rd_en, output rd_addr, input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data,
                 input rd_en, input rd_addr, output rd_data);
endinterface

// ===== src/frame_store.sv
// display image memory with registered read data
`timescale 1ns/10ps
module frame_store #(
  parameter int WORDS = 1024
) (
  input wire logic i_clk,
  frame_mem_if.store mem
);
  logic [$bits(mem.wr_data)-1:0] ram [WORDS];
  logic [$bits(mem.rd_data)-1:0] rd_q;

  always_ff @(posedge i_clk) begin
    if (mem.wr_en) begin
      ram[mem.wr_addr] <= mem.wr_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (mem.rd_en) begin
      rd_q <= ram[mem.rd_addr];
    end
  end

  assign mem.rd_data = rd_q;
endmodule // frame_store

// ===== verif/host_model.sv
// remote controller model that issues commands and polls to the status block
`timescale 1ns/10ps
module host_model (
  // clock
  input  wire logic       i_clk,
  // command port toward the device
  output logic            o_cmd_valid,
  output logic [2:0]      o_cmd_code,
  output logic [7:0]      o_cmd_data
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code  = 3'h0;
    o_cmd_data  = 8'h00;
  end

  // one-cycle strobe; idle lines carry the inverse so stale values never match
  task automatic issue(input logic [2:0] code, input logic [7:0] data);
    @(negedge i_clk);
    o_cmd_valid = 1'b1;
    o_cmd_code  = code;
    o_cmd_data  = data;
    @(negedge i_clk);
    o_cmd_valid = 1'b0;
    o_cmd_code  = ~code;
    o_cmd_data  = ~data;
  endtask
endmodule // host_model

// ===== verif/tb_status_byte_service_request.sv
// self-checking bench for the status byte and service request block
`timescale 1ns/10ps
module tb_status_byte_service_request;
  import stb_pkg::*;
  localparam int IDLE_CYC = 8;
  localparam int WORDS    = 8;

  logic       i_clk, i_rst_n, cmd_valid, rsp_valid, srq, ev, qne, value_adjusted_flag, internal_change_flag;
  logic       act, pix_we, disp_off, dump_valid, dump_last, dump_busy;
  logic [2:0] cmd_code, pix_addr;
  logic [7:0] cmd_data, rsp_data, pix_data, dump_data, m, st, px;
  logic [3:0] src;
  logic       mss;
  logic [7:0] exp_q[$];
  logic [8:0] dump_q[$];
  int         n_fail, check_count, n;

  host_model host (.i_clk(i_clk), .o_cmd_valid(cmd_valid), .o_cmd_code(cmd_code),
                   .o_cmd_data(cmd_data));

  status_byte_service_request #(.SAVER_IDLE_CYC(IDLE_CYC), .FRAME_WORDS(WORDS), .PIX_W(8)) dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_cmd_valid(cmd_valid), .i_cmd_code(cmd_code),
    .i_cmd_data(cmd_data), .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data),
    .o_service_request(srq), .i_event_summary(ev), .i_queue_not_empty(qne),
    .i_value_adjusted_flag(value_adjusted_flag), .i_internal_change_flag(internal_change_flag), .i_user_activity(act),
    .i_pix_we(pix_we), .i_pix_addr(pix_addr), .i_pix_data(pix_data),
    .o_display_off(disp_off), .o_dump_valid(dump_valid), .o_dump_data(dump_data),
    .o_dump_last(dump_last), .o_dump_busy(dump_busy));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic query(input logic [2:0] code, input logic [7:0] exp);
    exp_q.push_back(exp);
    host.issue(code, 8'h00);
  endtask

  task automatic cycles(input int k);
    repeat (k) @(negedge i_clk);
  endtask

  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // answers and dump words are matched against the oldest note
  always @(negedge i_clk) begin
    if (rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) chk({1'b0, rsp_data}, {1'b1, rsp_data});
      else chk({1'b0, rsp_data}, {1'b0, exp_q.pop_front()});
    end
    if (dump_valid === 1'b1) begin
      if (dump_q.size() == 0) chk({dump_last, dump_data}, ~{dump_last, dump_data});
      else chk({dump_last, dump_data}, dump_q.pop_front());
    end
  end

  initial begin
    n_fail = 0;
    check_count = 0;
    {i_rst_n, ev, qne, value_adjusted_flag, internal_change_flag, act, pix_we} = 7'h00;
    pix_addr = 3'h0;
    pix_data = 8'h00;
    void'($urandom(32'h6FCE4969));
    cycles(3);
    i_rst_n = 1'b1;
    query(CMD_MASK_QUERY, 8'h00);
    query(CMD_STATUS_QUERY, 8'h00);
    query(CMD_SAVER_QUERY, 8'h00);
    chk({5'h00, srq, disp_off, dump_valid, dump_busy}, 9'h000);
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      m = (i == 0) ? 8'hFF : (i == 1) ? 8'h40 : 8'($urandom);
      host.issue(CMD_MASK_WRITE, m);
      query(CMD_MASK_QUERY, m & 8'hBF);
    end
    $display("test mask done");

    for (int i = 0; i < 12; i++) begin
      src = (i == 0) ? 4'hF : 4'($urandom);
      m = (i == 0) ? 8'h00 : 8'($urandom);
      host.issue(CMD_MASK_WRITE, 8'h00);
      host.issue(CMD_CLEAR, 8'h00);
      {ev, qne, value_adjusted_flag, internal_change_flag} = src;
      cycles(1);
      {value_adjusted_flag, internal_change_flag} = 2'b00;
      st = {2'b00, src[3], src[2], 1'b0, src[1], 1'b0, src[0]};
      mss = |(st & m & 8'hBF);
      host.issue(CMD_MASK_WRITE, m);
      query(CMD_STATUS_QUERY, st | {1'b0, mss, 6'h00});
      chk({8'h00, srq}, {8'h00, mss});
      query(CMD_SERIAL_POLL, st | {1'b0, mss, 6'h00});
      query(CMD_SERIAL_POLL, st);
      chk({8'h00, srq}, 9'h000);
    end
    $display("test status done");

    {ev, qne} = 2'b01;
    host.issue(CMD_CLEAR, 8'h00);
    host.issue(CMD_MASK_WRITE, 8'h10);
    host.issue(CMD_SAVER_SET, SAVER_YES);
    query(CMD_SAVER_QUERY, 8'h01);
    act = 1'b1;
    cycles(1);
    act = 1'b0;
    n = 0;
    while (disp_off !== 1'b1 && n < 40) begin
      cycles(1);
      n++;
    end
    chk({1'b0, 8'(n)}, 9'(IDLE_CYC));
    query(CMD_STATUS_QUERY, 8'h50);
    chk({8'h00, disp_off}, 9'h001);
    act = 1'b1;
    cycles(1);
    act = 1'b0;
    cycles(1);
    chk({8'h00, disp_off}, 9'h000);
    host.issue(CMD_SAVER_SET, 8'h02);
    query(CMD_SAVER_QUERY, 8'h00);
    cycles(20);
    chk({8'h00, disp_off}, 9'h000);
    $display("test saver done");

    for (int i = 0; i < WORDS; i++) begin
      px = 8'($urandom);
      pix_we = 1'b1;
      pix_addr = 3'(i);
      pix_data = px;
      dump_q.push_back({i == WORDS - 1, px});
      cycles(1);
    end
    pix_we = 1'b0;
    host.issue(CMD_DUMP, 8'h00);
    host.issue(CMD_DUMP, 8'h00);
    n = 0;
    while (dump_busy === 1'b1 && n < 50) begin
      cycles(1);
      n++;
    end
    cycles(20);
    chk({8'h00, n < 50 && dump_q.size() == 0 && exp_q.size() == 0}, 9'h001);
    $display("test dump done");
    stop_test();
  end
endmodule // tb_status_byte_service_request
